// ==== bench/owdl_ctrl_monitor.sv ====
// Purpose: port checker for owdl_ctrl
// Assumes: one clock, sync reset high
// Notes: bound below the module
`timescale 1ns/1ns
module owdl_ctrl_monitor #(
    parameter int TIMEOUT_LIMIT = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic link_enable,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic sync_rise,
    input wire logic rx_to_tx,
    input wire logic byte_sent,
    input wire logic sync_character_event,
    input wire logic system_clock_request,
    input wire logic system_reset_out,
    input wire logic user_row_copy,
    input wire logic tx_hold,
    input wire logic [1:0] link_clock_choice,
    input wire logic link_active
);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic wr_ok;
    logic done_wr;
    logic [1:0] sel_in;
    logic turn;
    assign turn = rx_to_tx || byte_sent;
    assign wr_ok = reg_wr && link_active && link_enable;
    assign done_wr = reg_wr && reg_addr == 4'hA && reg_wdata[1];
    assign sel_in = reg_wdata[1:0];
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sync_evt_a: assert property (sync_rise && link_active |=> sync_character_event)
        else $error("sync event missing");
    dis_bit_a: assert property (wr_ok && reg_addr == 4'h3 && reg_wdata[2]
        |-> ##[1:2] !link_active && !system_clock_request)
        else $error("disable ignored");
    req_drop_a: assert property (wr_ok && reg_addr == 4'hA && !reg_wdata[0]
        |=> !system_clock_request) else $error("clock request kept");
    rst_req_a: assert property (wr_ok && reg_addr == 4'h8 && reg_wdata == 8'h59
        |=> system_reset_out) else $error("reset not raised");
    rst_clr_a: assert property (wr_ok && reg_addr == 4'h8 && reg_wdata != 8'h59
        |=> !system_reset_out) else $error("reset not cleared");
    rev_read_a: assert property (reg_rd && reg_addr == 4'h0 && link_active
        |=> reg_rdata[7:4] == owdl_pkg::REVISION_DEFAULT) else $error("revision wrong");
    clk_sel_a: assert property (wr_ok && reg_addr == 4'h9 && sel_in != 2'h0
        |=> link_clock_choice == $past(sel_in)) else $error("clock choice not taken");
    clk_keep_a: assert property (wr_ok && reg_addr == 4'h9 && sel_in == 2'h0
        |=> $stable(link_clock_choice)) else $error("clock choice 0 taken");
    urow_copy_a: assert property (user_row_copy |-> $past(done_wr))
        else $error("copy without write");
    guard_a: assert property ($rose(tx_hold) |-> $past(turn))
        else $error("hold without turn");
    cover property (rx_to_tx ##1 tx_hold);
    cover property (byte_sent ##1 tx_hold);
    cover property (sync_rise && link_active);
    cover property ($rose(system_reset_out));
endmodule : owdl_ctrl_monitor
bind owdl_ctrl owdl_ctrl_monitor #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) u_mon (
    .clock(clock), .rst(rst), .link_enable(link_enable), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_rise(sync_rise),
    .rx_to_tx(rx_to_tx), .byte_sent(byte_sent), .sync_character_event(sync_character_event),
    .system_clock_request(system_clock_request), .system_reset_out(system_reset_out),
    .user_row_copy(user_row_copy), .tx_hold(tx_hold), .link_clock_choice(link_clock_choice),
    .link_active(link_active)
);

// ==== bench/owdl_dbg_model.sv ====
// Purpose: debugger-side register access model
// Assumes: one access at a time, driven at falling edges
// Notes: idle address and data show the inverted last value
`timescale 1ns/1ns
module owdl_dbg_model (
    input wire logic clock,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    end
    // single write: strobe for one cycle, then idle with inverted address and data
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clock);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clock);
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clock);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clock);
        {reg_rd, reg_addr} = {1'b0, ~a};
        d = reg_rdata;
    endtask : rd
endmodule : owdl_dbg_model

// ==== bench/tb.sv ====
// Purpose: self-checking bench for owdl_ctrl
// Assumes: debugger model makes all register accesses
// Notes: time-out limit shortened to 16
`timescale 1ns/1ns
module tb;
    typedef struct packed {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e;} owdl_row_t;
    localparam int LIM = 16;
    logic clock, rst, link_enable, access_wait, byte_sent, access_resp, prog_started;
    logic sys_sleeping, sys_in_reset, sys_locked, urow_ready, reg_wr, reg_rd, tx_hold;
    logic [9:0] pls;
    logic [2:0] crc_state;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic sync_character_event, system_clock_request, system_reset_out, user_row_copy;
    logic timeout_flag, parity_check_off, response_signature_off, negative_ack_off;
    logic contention_check_off, inter_byte_gap_enable, link_active;
    logic [1:0] link_clock_choice;
    int fails, n_checks, cycles, n;
    owdl_row_t rows [15] = '{'{1'h0, 4'h0, 8'h00, {owdl_pkg::REVISION_DEFAULT, 4'h0}},
        '{1'h0, 4'h1, 8'h00, 8'h00}, '{1'h0, 4'h2, 8'h00, 8'h00}, '{1'h0, 4'h3, 8'h00, 8'h00},
        '{1'h0, 4'hA, 8'h00, 8'h01}, '{1'h0, 4'h9, 8'h00, 8'h03}, '{1'h0, 4'hB, 8'h00, 8'h01},
        '{1'h0, 4'hC, 8'h00, 8'h00}, '{1'h0, 4'h5, 8'h00, 8'h00}, '{1'h1, 4'h9, 8'h01, 8'h01},
        '{1'h1, 4'h9, 8'h00, 8'h01}, '{1'h1, 4'h9, 8'h02, 8'h02}, '{1'h1, 4'h9, 8'h03, 8'h03},
        '{1'h1, 4'h2, 8'hFF, 8'hBF}, '{1'h1, 4'h3, 8'h18, 8'h18}};
    logic [2:0] ecode [5] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
    owdl_ctrl #(.TIMEOUT_LIMIT(LIM)) uut (
        .clock(clock), .rst(rst), .link_enable(link_enable), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_rise(pls[8]),
        .err_parity(pls[0]), .err_frame(pls[1]), .err_clock(pls[2]), .err_bus(pls[3]),
        .err_contention(pls[4]), .access_wait(access_wait), .access_resp(access_resp),
        .rx_to_tx(pls[9]), .byte_sent(byte_sent), .key_urow_ok(pls[5]), .key_prog_ok(pls[6]),
        .key_erase_ok(pls[7]), .prog_started(prog_started), .sys_sleeping(sys_sleeping),
        .sys_in_reset(sys_in_reset), .sys_locked(sys_locked), .urow_ready(urow_ready),
        .crc_state(crc_state), .sync_character_event(sync_character_event),
        .system_clock_request(system_clock_request), .system_reset_out(system_reset_out),
        .user_row_copy(user_row_copy), .tx_hold(tx_hold), .timeout_flag(timeout_flag),
        .link_clock_choice(link_clock_choice), .parity_check_off(parity_check_off),
        .response_signature_off(response_signature_off), .negative_ack_off(negative_ack_off),
        .contention_check_off(contention_check_off), .link_active(link_active),
        .inter_byte_gap_enable(inter_byte_gap_enable));
    owdl_dbg_model m (.clock(clock), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    // ----------------------------------------
    // clock, watchdog, helpers
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] exp);
        m.rd(a, v);
        check(nm, v, exp);
    endtask : rchk
    task automatic pulse(input logic [10:0] p);
        @(negedge clock);
        {byte_sent, pls} = p;
        @(negedge clock);
        {byte_sent, pls} = '0;
    endtask : pulse
    task automatic finish_test;
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst, link_enable, sys_locked, cycles, fails, n_checks} = {3'h7, 96'h0};
        {access_wait, byte_sent, access_resp, pls, crc_state} = '0;
        {prog_started, sys_sleeping, sys_in_reset, urow_ready} = '0;
        repeat (10) @(negedge clock);
        check("rst clk", {6'h0, link_clock_choice}, 8'h03);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        foreach (rows[i]) begin
            if (rows[i].w) begin
                m.wr(rows[i].a, rows[i].d);
            end
            rchk("table", rows[i].a, rows[i].e);
        end
        check("cfg", {3'h0, inter_byte_gap_enable, parity_check_off, response_signature_off,
            negative_ack_off, contention_check_off}, 8'h1F);
        pulse(11'h011);
        rchk("par off", 4'h1, 8'h00);
        for (int c = 0; c < 9; c++) begin
            m.wr(4'h2, c == 8 ? 8'h80 : 8'(c));
            pulse(c == 8 ? 11'h400 : 11'h200);
            for (n = 0; tx_hold === 1'b1 && n < 200; n++) begin
                @(negedge clock);
            end
            v = c == 8 ? 8'(owdl_pkg::GAP_BITS) : 8'(128 >> (c == 7 ? 6 : c));
            check("guard", 8'(n), v);
        end
        m.wr(4'h3, 8'h00);
        for (int i = 0; i < 5; i++) begin
            pulse(11'(1 << i));
            rchk("err", 4'h1, {5'h0, ecode[i]});
            rchk("err clr", 4'h1, 8'h00);
        end
        pulse(11'h011);
        rchk("err prio", 4'h1, 8'h07);
        access_wait = 1'b1;
        for (n = 0; timeout_flag !== 1'b1 && n < 40; n++) begin
            @(negedge clock);
        end
        access_wait = 1'b0;
        check("tmo", 8'(n), 8'(LIM));
        rchk("tmo code", 4'h1, 8'h03);
        m.wr(4'h2, 8'h10);
        access_wait = 1'b1;
        n = 0;
        repeat (LIM + 8) begin
            @(negedge clock);
            n += (timeout_flag !== 1'b0);
        end
        access_wait = 1'b0;
        check("tmo off", 8'(n), 8'h00);
        sys_sleeping = 1'b1;
        pulse(11'h100);
        check("sync", {6'h0, sync_character_event, system_clock_request}, 8'h03);
        m.wr(4'h8, 8'h59);
        check("sysrst", {7'h0, system_reset_out}, 8'h01);
        rchk("held", 4'hB, 8'h31);
        m.wr(4'h8, 8'h12);
        check("sysrst clr", {7'h0, system_reset_out}, 8'h00);
        rchk("sticky", 4'hB, 8'h31);
        rchk("rd clr", 4'hB, 8'h11);
        sys_sleeping = 1'b0;
        m.wr(4'hA, 8'h03);
        check("no key", {7'h0, user_row_copy}, 8'h00);
        pulse(11'h0E0);
        rchk("keys", 4'h7, 8'h38);
        m.wr(4'hA, 8'h03);
        check("copy", {7'h0, user_row_copy}, 8'h01);
        m.wr(4'h7, 8'h20);
        m.wr(4'h8, 8'h59);
        m.wr(4'h8, 8'h00);
        rchk("erase clr", 4'h7, 8'h10);
        {prog_started, urow_ready} = 2'h3;
        rchk("prog clr", 4'h7, 8'h00);
        rchk("prog", 4'hB, 8'h2D);
        sys_locked = 1'b0;
        rchk("unlock", 4'hB, 8'h0C);
        for (int c = 0; c < 3; c++) begin
            crc_state = 3'(1 << c);
            rchk("crc", 4'hC, 8'(1 << c));
        end
        m.wr(4'hA, 8'h00);
        check("system_clock_request", {7'h0, system_clock_request}, 8'h00);
        m.wr(4'h9, 8'h01);
        m.wr(4'h3, 8'h04);
        repeat (3) @(negedge clock);
        check("dis", {2'h0, link_clock_choice, link_active, system_clock_request, negative_ack_off,
            contention_check_off}, 8'h30);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        rchk("re clk", 4'h9, 8'h03);
        finish_test();
    end
endmodule : tb

// ==== design/owdl_ctrl.sv ====
// Purpose: control and status registers of the one-wire debug link
// Assumes: clock is the link domain clock; register port byte wide
// Notes: inputs synchronous; all outputs registered
`timescale 1ns/1ns
module owdl_ctrl #(
    parameter int TIMEOUT_LIMIT = owdl_pkg::TIMEOUT_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic link_enable,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic sync_rise,
    input wire logic err_parity,
    input wire logic err_frame,
    input wire logic err_clock,
    input wire logic err_bus,
    input wire logic err_contention,
    input wire logic access_wait,
    input wire logic access_resp,
    input wire logic rx_to_tx,
    input wire logic byte_sent,
    input wire logic key_urow_ok,
    input wire logic key_prog_ok,
    input wire logic key_erase_ok,
    input wire logic prog_started,
    input wire logic sys_sleeping,
    input wire logic sys_in_reset,
    input wire logic sys_locked,
    input wire logic urow_ready,
    input wire logic [2:0] crc_state,
    output logic sync_character_event,
    output logic system_clock_request,
    output logic system_reset_out,
    output logic user_row_copy,
    output logic tx_hold,
    output logic timeout_flag,
    output logic [1:0] link_clock_choice,
    output logic parity_check_off,
    output logic response_signature_off,
    output logic negative_ack_off,
    output logic contention_check_off,
    output logic inter_byte_gap_enable,
    output logic link_active
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_ON = 3'b010,
        ST_GAP = 3'b100
    } owdl_mode_t;

    typedef struct packed {
        owdl_mode_t mode;
        logic [7:0] ctrl_pri;
        logic [7:0] ctrl_sec;
        logic [2:0] err_sig;
        logic urow_key;
        logic prog_key;
        logic erase_key;
        logic [7:0] reset_req;
        logic [1:0] clk_sel;
        logic clk_req;
        logic urow_done;
        logic rst_seen;
        logic [16:0] tmo_cnt;
        logic [7:0] guard_cnt;
        logic [1:0] gap_cnt;
        logic [7:0] rdata;
        logic sync_ev;
        logic tmo;
    } owdl_state_t;

    owdl_state_t s_r;
    owdl_state_t s_nxt;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] owdl_guard(input logic [2:0] code);
        owdl_guard = owdl_pkg::GUARD_MAX >> code;
    endfunction : owdl_guard

    function automatic logic owdl_hit(input logic [3:0] a, input logic [3:0] ofs);
        owdl_hit = (a == ofs);
    endfunction : owdl_hit

    logic [7:0] sys_status;
    assign sys_status = {2'h0, s_r.rst_seen | sys_in_reset, sys_sleeping,
                         s_r.prog_key == 1'b0 && prog_started, urow_ready, 1'b0, sys_locked};

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync_ev = sync_rise && s_r.mode != ST_OFF;
        s_nxt.tmo = 1'b0;
        if (sys_in_reset || system_reset_out) begin
            s_nxt.rst_seen = 1'b1;
        end
        // error capture
        if (err_contention && !s_r.ctrl_sec[owdl_pkg::BIT_CONT_OFF]) begin
            s_nxt.err_sig = owdl_pkg::ERR_CONTENTION;
        end else if (err_bus) begin
            s_nxt.err_sig = owdl_pkg::ERR_BUS;
        end else if (err_clock) begin
            s_nxt.err_sig = owdl_pkg::ERR_CLOCK;
        end else if (err_frame) begin
            s_nxt.err_sig = owdl_pkg::ERR_FRAME;
        end else if (err_parity && !s_r.ctrl_pri[owdl_pkg::BIT_PARITY_OFF]) begin
            s_nxt.err_sig = owdl_pkg::ERR_PARITY;
        end else if (reg_rd && owdl_hit(reg_addr, owdl_pkg::OFS_ERR_STATUS)) begin
            s_nxt.err_sig = owdl_pkg::ERR_NONE;
        end
        // time-out watch
        if (access_resp || !access_wait || s_r.ctrl_pri[owdl_pkg::BIT_TIMEOUT_OFF]) begin
            s_nxt.tmo_cnt = '0;
        end else if (s_r.tmo_cnt == 17'(TIMEOUT_LIMIT - 1)) begin
            s_nxt.tmo_cnt = '0;
            s_nxt.tmo = 1'b1;
            s_nxt.err_sig = owdl_pkg::ERR_TIMEOUT;
        end else begin
            s_nxt.tmo_cnt = s_r.tmo_cnt + 17'h00001;
        end
        // guard time
        if (rx_to_tx) begin
            s_nxt.guard_cnt = owdl_guard(s_r.ctrl_pri[2:0] > owdl_pkg::GUARD_MAX_CODE ?
                                         owdl_pkg::GUARD_MAX_CODE : s_r.ctrl_pri[2:0]);
        end else if (s_r.guard_cnt != 8'h00) begin
            s_nxt.guard_cnt = s_r.guard_cnt - 8'h01;
        end
        // keys: set wins over clear
        if (key_prog_ok) begin
            s_nxt.prog_key = 1'b1;
        end else if (prog_started) begin
            s_nxt.prog_key = 1'b0;
        end
        if (key_erase_ok) begin
            s_nxt.erase_key = 1'b1;
        end else if (reg_wr && owdl_hit(reg_addr, owdl_pkg::OFS_RESET_REQ)
                     && reg_wdata == owdl_pkg::RESET_CODE) begin
            s_nxt.erase_key = 1'b0;
        end
        if (key_urow_ok) begin
            s_nxt.urow_key = 1'b1;
        end else if (reg_wr && owdl_hit(reg_addr, owdl_pkg::OFS_KEY_STATUS)
                     && reg_wdata[owdl_pkg::BIT_UROW_KEY]) begin
            s_nxt.urow_key = 1'b0;
        end
        s_nxt.urow_done = 1'b0;
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                owdl_pkg::OFS_CTRL_PRI: s_nxt.ctrl_pri = reg_wdata & 8'hBF;
                owdl_pkg::OFS_CTRL_SEC: s_nxt.ctrl_sec = reg_wdata & 8'h1C;
                owdl_pkg::OFS_RESET_REQ: s_nxt.reset_req = reg_wdata;
                owdl_pkg::OFS_CLK_SEL: begin
                    if (reg_wdata[1:0] != 2'h0) begin
                        s_nxt.clk_sel = reg_wdata[1:0];
                    end
                end
                owdl_pkg::OFS_SYS_CTRL: begin
                    s_nxt.clk_req = reg_wdata[owdl_pkg::BIT_CLK_REQ];
                    s_nxt.urow_done = reg_wdata[owdl_pkg::BIT_UROW_DONE] && s_r.urow_key;
                end
                default: begin
                end
            endcase
        end
        // register reads
        s_nxt.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                owdl_pkg::OFS_REV_STATUS: s_nxt.rdata = {owdl_pkg::REVISION_DEFAULT, 4'h0};
                owdl_pkg::OFS_ERR_STATUS: s_nxt.rdata = {5'h00, s_r.err_sig};
                owdl_pkg::OFS_CTRL_PRI: s_nxt.rdata = s_r.ctrl_pri;
                owdl_pkg::OFS_CTRL_SEC: s_nxt.rdata = s_r.ctrl_sec;
                owdl_pkg::OFS_KEY_STATUS: s_nxt.rdata = {2'h0, s_r.urow_key, s_r.prog_key,
                                                         s_r.erase_key, 3'h0};
                owdl_pkg::OFS_RESET_REQ: s_nxt.rdata = s_r.reset_req;
                owdl_pkg::OFS_CLK_SEL: s_nxt.rdata = {6'h00, s_r.clk_sel};
                owdl_pkg::OFS_SYS_CTRL: s_nxt.rdata = {7'h00, s_r.clk_req};
                owdl_pkg::OFS_SYS_STATUS: begin
                    s_nxt.rdata = sys_status;
                    if (!(sys_in_reset || system_reset_out)) begin
                        s_nxt.rst_seen = 1'b0;
                    end
                end
                owdl_pkg::OFS_CRC_STATUS: s_nxt.rdata = {5'h00, crc_state};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        // link mode: enable and transmit gap
        case (s_r.mode)
            ST_OFF: begin
                if (link_enable) begin
                    s_nxt.mode = ST_ON;
                    s_nxt.clk_req = 1'b1;
                    s_nxt.clk_sel = owdl_pkg::CLK_SEL_RESET;
                end
            end
            ST_ON: begin
                if (byte_sent && s_r.ctrl_pri[owdl_pkg::BIT_GAP_EN]) begin
                    s_nxt.mode = ST_GAP;
                    s_nxt.gap_cnt = owdl_pkg::GAP_BITS;
                end
            end
            ST_GAP: begin
                s_nxt.gap_cnt = s_r.gap_cnt - 2'h1;
                if (s_r.gap_cnt == 2'h1) begin
                    s_nxt.mode = ST_ON;
                end
            end
            default: s_nxt.mode = ST_OFF;
        endcase
        // disable resets mode, config, clock request, keys, guard and time-out counters, not the error signature or the system reset request
        if (s_r.ctrl_sec[owdl_pkg::BIT_LINK_DIS] || !link_enable) begin
            s_nxt.mode = ST_OFF;
            s_nxt.ctrl_pri = 8'h00;
            s_nxt.ctrl_sec = 8'h00;
            s_nxt.ctrl_sec[owdl_pkg::BIT_LINK_DIS] = link_enable
                && s_r.ctrl_sec[owdl_pkg::BIT_LINK_DIS];
            s_nxt.clk_req = 1'b0;
            s_nxt.urow_key = 1'b0;
            s_nxt.prog_key = 1'b0;
            s_nxt.erase_key = 1'b0;
            s_nxt.clk_sel = owdl_pkg::CLK_SEL_RESET;
            s_nxt.guard_cnt = 8'h00;
            s_nxt.tmo_cnt = '0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '{mode: ST_OFF, clk_sel: owdl_pkg::CLK_SEL_RESET, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // outputs from flops
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            system_reset_out <= 1'b0;
            tx_hold <= 1'b0;
        end else begin
            system_reset_out <= s_nxt.reset_req == owdl_pkg::RESET_CODE;
            tx_hold <= s_nxt.guard_cnt != 8'h00 || s_nxt.mode == ST_GAP;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign sync_character_event = s_r.sync_ev;
    assign system_clock_request = s_r.clk_req;
    assign user_row_copy = s_r.urow_done;
    assign timeout_flag = s_r.tmo;
    assign link_clock_choice = s_r.clk_sel;
    assign parity_check_off = s_r.ctrl_pri[owdl_pkg::BIT_PARITY_OFF];
    assign response_signature_off = s_r.ctrl_pri[owdl_pkg::BIT_RESP_OFF];
    assign negative_ack_off = s_r.ctrl_sec[owdl_pkg::BIT_NACK_OFF];
    assign contention_check_off = s_r.ctrl_sec[owdl_pkg::BIT_CONT_OFF];
    assign inter_byte_gap_enable = s_r.ctrl_pri[owdl_pkg::BIT_GAP_EN];
    assign link_active = s_r.mode != ST_OFF;
endmodule : owdl_ctrl

// ==== design/owdl_pkg.sv ====
// Purpose: constants for the one-wire debug link control and status block
// Assumes: byte-wide register port, offsets as printed
// Notes: revision value is arbitrary
// Operation
// - pulse event output for each rising edge inside a received sync character
// - link logic keeps running in sleep; enabled link requests system clock
// - clock request bit holds clock when 1, set on enable, cleared on disable
// - sleeping flag reads 1 in idle or deeper sleep, else 0
// - upper nibble of first status register holds read-only revision
// - error signature loads on link error, clears when debugger reads it
// - error codes: 1 parity,2 frame,3 timeout,4 clock recovery,6 bus,7 contention
// - gap enable inserts two idle bits between transmitted load bytes
// - parity check off ignores parity bit and reports no parity errors
// - time-out flagged after 65536 link cycles without access-layer response
// - response signature off suppresses all response signatures
// - guard time on rx-to-tx: code 0 is 128 cycles, halving to 2 at code 6
// - negative ack off suppresses reset nack; contention check off disables detection
// - link disable turns link off, drops clock request, clears config and keys
// - user row key flag set on decode; debugger writes it to end session
// - programming key clears when programming starts; erase key clears on reset request
// - writing 0x59 asserts system reset, any other value clears it
// - clock choice 1:16MHz 2:8MHz 3:4MHz, default 3 after reset and enable
// - user row done starts flash copy, writable only after user row key decode
// - system reset active reads 1 during any system reset, clears on read
// - locked flag resets to 1, clears after erase; start flag shows ready
// - memory check status one-hot: 0 off,1 busy,2 pass,4 fail
package owdl_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [3:0] OFS_REV_STATUS = 4'h0;
    localparam logic [3:0] OFS_ERR_STATUS = 4'h1;
    localparam logic [3:0] OFS_CTRL_PRI = 4'h2;
    localparam logic [3:0] OFS_CTRL_SEC = 4'h3;
    localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
    localparam logic [3:0] OFS_RESET_REQ = 4'h8;
    localparam logic [3:0] OFS_CLK_SEL = 4'h9;
    localparam logic [3:0] OFS_SYS_CTRL = 4'hA;
    localparam logic [3:0] OFS_SYS_STATUS = 4'hB;
    localparam logic [3:0] OFS_CRC_STATUS = 4'hC;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_GAP_EN = 7;
    localparam int BIT_PARITY_OFF = 5;
    localparam int BIT_TIMEOUT_OFF = 4;
    localparam int BIT_RESP_OFF = 3;
    localparam int BIT_NACK_OFF = 4;
    localparam int BIT_CONT_OFF = 3;
    localparam int BIT_LINK_DIS = 2;
    localparam int BIT_UROW_KEY = 5;
    localparam int BIT_PROG_KEY = 4;
    localparam int BIT_ERASE_KEY = 3;
    localparam int BIT_UROW_DONE = 1;
    localparam int BIT_CLK_REQ = 0;
    // ----------------------------------------
    // reset values and codes
    // ----------------------------------------
    localparam logic [3:0] REVISION_DEFAULT = 4'h2; // arbitrary value
    localparam logic [1:0] CLK_SEL_RESET = 2'h3;
    localparam logic [7:0] RESET_CODE = 8'h59;
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_PARITY = 3'h1;
    localparam logic [2:0] ERR_FRAME = 3'h2;
    localparam logic [2:0] ERR_TIMEOUT = 3'h3;
    localparam logic [2:0] ERR_CLOCK = 3'h4;
    localparam logic [2:0] ERR_BUS = 3'h6;
    localparam logic [2:0] ERR_CONTENTION = 3'h7;
    localparam logic [2:0] CRC_OFF = 3'h0;
    localparam logic [2:0] CRC_BUSY = 3'h1;
    localparam logic [2:0] CRC_PASS = 3'h2;
    localparam logic [2:0] CRC_FAIL = 3'h4;
    // ----------------------------------------
    // timing counts
    // ----------------------------------------
    localparam int TIMEOUT_CYCLES = 65536;
    localparam logic [7:0] GUARD_MAX = 8'h80;
    localparam logic [2:0] GUARD_MAX_CODE = 3'h6;
    localparam logic [1:0] GAP_BITS = 2'h2;
endpackage : owdl_pkg
